/* File: target_char_mailbox.sv */
// character mailbox between the controlling port and a program on the target
// assumes a target memory port with a one-cycle ack, and run/break status
// from the emulator on the same clock
// How it works
// - poll outbound byte once per half second
// - every target access halts emulation 100us
// - new character: read, clear, forward it
// - resample soon after collect, else next poll
// - base byte outbound, base+1 inbound
// - low seven bits character, top bit flag
// - inbound written without checking acknowledgement
// - two escapes end mailbox mode
// - transfers only while target runs
// - break stalls; escape exits and reports
module target_char_mailbox
    import mailbox_pkg::*;
#(
    parameter int POLL_CYCLES = POLL_CYC  // half-second poll, shorten for simulation
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // mode control and emulator status
    input  wire logic              bridge_start,
    input  wire logic [ADDR_W-1:0] bridge_addr,
    input  wire logic              run_mode,
    input  wire logic              break_pending,
    output logic                   mailbox_active,
    output logic                   report_break,
    // characters from the controlling port
    input  wire logic              host_valid,
    input  wire logic [CHAR_W-1:0] host_data,
    output logic                   host_ready,
    // characters to the controlling port
    output logic                   out_valid,
    output logic [CHAR_W-1:0]      out_data,
    input  wire logic              out_ready,
    // target memory access
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [7:0]             mem_wdata,
    input  wire logic              mem_ack,
    input  wire logic [7:0]        mem_rdata,
    output logic                   halt_emul
);
    typedef struct packed {
        mbox_state_t       st;        // sequencer state
        logic [23:0]       tmr;       // poll and gap timer
        logic [11:0]       hcnt;      // cycles spent halted
        logic [ADDR_W-1:0] base;      // outbound byte address
        logic [CHAR_W-1:0] chr;       // collected character
        logic              got;       // a character awaits forwarding
        logic              esc;       // last host character was escape
        logic              req;       // memory request
        logic              we;        // memory write
        logic [ADDR_W-1:0] addr;      // memory address
        logic [7:0]        wdata;     // memory write data
        logic              halt;      // emulation halted
        logic              hrdy;      // host character may be taken
        logic              active;    // mailbox mode on
        logic              report;    // break report pulse
        logic              push;      // character offered to buffer
    } mbox_t;

    mbox_t s;
    mbox_t next_s;

    char_stream_if to_buf ();
    char_stream_if from_buf ();

    // buffer absorbs port stalls; its ready holds the sequencer in ST_PUSH
    char_buffer u_buf (
        .clk   (clk),
        .rst_b (rst_b),
        .inp   (to_buf.snk),
        .outp  (from_buf.src)
    );

    assign to_buf.valid   = s.push;
    assign to_buf.data    = s.chr;
    assign from_buf.ready = out_ready;

    // next-state logic of the sequencer
    always_comb begin
        logic host_take;
        logic go_read;
        host_take = s.hrdy && host_valid;
        go_read   = 1'b0;
        next_s    = s;
        next_s.report = 1'b0;
        // halt length counted over the whole access
        if (s.halt) begin
            next_s.hcnt = s.hcnt + 12'h001;
        end
        case (s.st)
            ST_OFF: begin
                if (bridge_start) begin
                    next_s.base   = bridge_addr;
                    next_s.active = 1'b1;
                    next_s.esc    = 1'b0;
                    next_s.tmr    = '0;
                    next_s.st     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (host_take) begin
                    if (host_data == ESC_CHAR && s.esc) begin
                        // second escape leaves the mode, even while the target is stopped
                        next_s.active = 1'b0;
                        next_s.report = break_pending;
                        next_s.st     = ST_OFF;
                    end else begin
                        next_s.esc = (host_data == ESC_CHAR);
                        // target not running: nobody would take it, so drop it
                        if (run_mode) begin
                            // posted at once, no look at the previous one
                            next_s.req   = 1'b1;
                            next_s.we    = 1'b1;
                            next_s.addr  = s.base + IN_OFS;
                            next_s.wdata = {1'b1, host_data};
                            next_s.halt  = 1'b1;
                            next_s.hcnt  = '0;
                            next_s.st    = ST_WRIN;
                        end
                    end
                end else if (run_mode) begin
                    // timer freezes while stopped at a break
                    if (s.tmr >= 24'(POLL_CYCLES - 1)) begin
                        go_read = 1'b1;
                    end else begin
                        next_s.tmr = s.tmr + 24'h000001;
                    end
                end
            end
            ST_READ: begin
                if (mem_ack) begin
                    next_s.req = 1'b0;
                    if (mem_rdata[FLAG_BIT]) begin
                        next_s.chr = mem_rdata[CHAR_W-1:0];
                        next_s.got = 1'b1;
                        next_s.st  = ST_CLEAR;
                    end else begin
                        next_s.st = ST_HOLD;
                    end
                end
            end
            ST_CLEAR: begin
                // clearing frees the byte for the target's next character
                if (!s.req) begin
                    next_s.req   = 1'b1;
                    next_s.we    = 1'b1;
                    next_s.wdata = 8'h00;
                end else if (mem_ack) begin
                    next_s.req = 1'b0;
                    next_s.st  = ST_HOLD;
                end
            end
            ST_WRIN: begin
                if (mem_ack) begin
                    next_s.req = 1'b0;
                    next_s.st  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (s.hcnt >= 12'(HALT_CYC - 1)) begin
                    next_s.halt = 1'b0;
                    next_s.st   = s.got ? ST_PUSH : ST_WAIT;
                end
            end
            ST_PUSH: begin
                if (s.push && to_buf.ready) begin
                    next_s.push = 1'b0;
                    next_s.got  = 1'b0;
                    next_s.tmr  = '0;
                    next_s.st   = ST_GAP;
                end else begin
                    next_s.push = 1'b1;
                end
            end
            ST_GAP: begin
                // short window for the target's next character
                if (s.tmr >= 24'(GAP_CYC - 1)) begin
                    // a stopped target restarts the poll interval from zero
                    next_s.tmr = '0;
                    go_read = run_mode;
                    next_s.st = run_mode ? ST_GAP : ST_WAIT;
                end else begin
                    next_s.tmr = s.tmr + 24'h000001;
                end
            end
            default: begin
                next_s = '0;
            end
        endcase
        // one outbound sample, restarting the half-second interval
        if (go_read) begin
            next_s.req  = 1'b1;
            next_s.we   = 1'b0;
            next_s.addr = s.base;
            next_s.halt = 1'b1;
            next_s.hcnt = '0;
            next_s.tmr  = '0;
            next_s.st   = ST_READ;
        end
        next_s.hrdy = (next_s.st == ST_WAIT);
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mailbox_active = s.active;
    assign report_break   = s.report;
    assign host_ready     = s.hrdy;
    assign out_valid      = from_buf.valid;
    assign out_data       = from_buf.data;
    assign mem_req        = s.req;
    assign mem_we         = s.we;
    assign mem_addr       = s.addr;
    assign mem_wdata      = s.wdata;
    assign halt_emul      = s.halt;

    // no target access without emulation halted
    a_halt_covers_access: assert property (@(posedge clk) disable iff (!rst_b)
        mem_req |-> halt_emul) else $error("target accessed without halt");

    // a halt lasts at least eight cycles
    a_halt_min_length: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(halt_emul) |-> halt_emul [*8]) else $error("halt too short");

    // a flagged outbound byte is cleared next
    a_clear_after_take: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == ST_READ && mem_ack && mem_rdata[FLAG_BIT])
        |=> ##1 (mem_req && mem_we && mem_wdata == 8'h00 && mem_addr == s.base))
        else $error("outbound byte not cleared");

    // inbound writes carry the new flag at base plus one
    a_inbound_flagged: assert property (@(posedge clk) disable iff (!rst_b)
        (mem_req && mem_we && mem_wdata != 8'h00)
        |-> (mem_wdata[FLAG_BIT] && mem_addr == s.base + IN_OFS))
        else $error("inbound write malformed");

    // reads only ever look at the outbound byte
    a_reads_outbound: assert property (@(posedge clk) disable iff (!rst_b)
        (mem_req && !mem_we) |-> mem_addr == s.base) else $error("read off base");

    // an outbound sample from ST_WAIT starts only after the full poll wait
    a_poll_spacing: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == ST_WAIT && next_s.st == ST_READ) |-> s.tmr == 24'(POLL_CYCLES - 1))
        else $error("polled too early");

    // no access starts while out of the mode or while the target is stopped in ST_WAIT
    a_quiet_when_idle: assert property (@(posedge clk) disable iff (!rst_b)
        (!mailbox_active || (s.st == ST_WAIT && !run_mode))
        |=> !$rose(mem_req)) else $error("access while idle");

    // two escapes close the mode and report a pending break
    a_escape_exit: assert property (@(posedge clk) disable iff (!rst_b)
        (host_ready && host_valid && host_data == ESC_CHAR && s.esc && s.st == ST_WAIT)
        |=> (!mailbox_active && report_break == $past(break_pending)))
        else $error("escape sequence not honoured");

    // report is a single pulse
    a_report_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        report_break |=> !report_break) else $error("report longer than one cycle");
endmodule

/* File: mailbox_pkg.sv */
// constants shared by the character mailbox and its two-entry buffer
// assumes a single 25 MHz clock and a synchronous active-low reset
package mailbox_pkg;
    // clock rate
    localparam int          CLK_HZ     = 25_000_000;
    // mailbox layout in target memory
    localparam int          ADDR_W     = 20;
    localparam int          CHAR_W     = 7;
    localparam int          FLAG_BIT   = 7;
    localparam logic [19:0] IN_OFS     = 20'h00001;
    // escape character ending the mode, sent twice
    localparam logic [6:0]  ESC_CHAR   = 7'h1B;
    // times in their own units, then as cycle counts
    localparam real         POLL_S     = 0.5;
    localparam int          HALT_US    = 100;
    localparam int          GAP_US     = 100;
    localparam int          POLL_CYC   = int'(POLL_S * CLK_HZ);
    localparam int          HALT_CYC   = HALT_US * (CLK_HZ / 1_000_000);
    localparam int          GAP_CYC    = GAP_US * (CLK_HZ / 1_000_000);
    // buffer depth
    localparam int          BUF_DEPTH  = 2;
    // mailbox sequencer states
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_WAIT  = 3'h1,
        ST_READ  = 3'h2,
        ST_CLEAR = 3'h3,
        ST_HOLD  = 3'h4,
        ST_PUSH  = 3'h5,
        ST_WRIN  = 3'h6,
        ST_GAP   = 3'h7
    } mbox_state_t;
endpackage

/* File: char_stream_if.sv */
// valid/ready carrier for 7-bit characters between the mailbox and its buffer
// assumes both ends run on the same clock
interface char_stream_if;
    import mailbox_pkg::*;
    logic              valid;  // character offered
    logic              ready;  // character may be taken
    logic [CHAR_W-1:0] data;   // 7-bit character
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: char_buffer.sv */
// two-entry character buffer between the mailbox and the controlling port
// assumes one clock; ready and valid come straight from flip-flops
module char_buffer
    import mailbox_pkg::*;
(
    // clock and reset
    input wire logic   clk,
    input wire logic   rst_b,
    // filling side
    char_stream_if.snk inp,
    // draining side
    char_stream_if.src outp
);
    typedef struct packed {
        logic [BUF_DEPTH-1:0][CHAR_W-1:0] slot;  // stored characters
        logic                             wr;    // write index
        logic                             rd;    // read index
        logic [1:0]                       cnt;   // entries held
        logic                             rdy;   // room left
        logic                             vld;   // something held
        logic [CHAR_W-1:0]                head;  // oldest character, kept in a flop
    } buf_t;

    buf_t s;
    buf_t next_s;

    // flags are recomputed from the next count so they stay registered
    always_comb begin
        logic push;
        logic pop;
        push   = inp.valid && s.rdy;
        pop    = s.vld && outp.ready;
        next_s = s;
        if (push) begin
            next_s.slot[s.wr] = inp.data;
            next_s.wr         = ~s.wr;
        end
        if (pop) begin
            next_s.rd = ~s.rd;
        end
        next_s.cnt = s.cnt + 2'(push) - 2'(pop);
        next_s.rdy = (next_s.cnt != 2'(BUF_DEPTH));
        next_s.vld = (next_s.cnt != 2'h0);
        // registered copy of the oldest slot, so the port sees no slot mux
        next_s.head = next_s.slot[next_s.rd];
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s     <= '0;
            s.rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign inp.ready  = s.rdy;
    assign outp.valid = s.vld;
    assign outp.data  = s.head;
endmodule

/* File: target_prog_model.sv */
// target program model: owns the two mailbox bytes and answers the memory port
// assumes mem_* are driven after a rising edge and held until mem_ack is seen
module target_prog_model
    import mailbox_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // target state seen by the program
    input  wire logic              run_mode,
    input  wire logic              halt_emul,
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic              echo_en,
    input  wire logic [3:0]        ack_dly,
    // memory port
    input  wire logic              mem_req,
    input  wire logic              mem_we,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]        mem_wdata,
    output logic                   mem_ack,
    output logic [7:0]             mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]        ob;       // outbound byte at base
    logic [7:0]        ib;       // inbound byte at base+1
    logic [7:0]        in_wr;    // last byte written inbound
    logic [CHAR_W-1:0] rx_char;  // last character taken
    int                rx_cnt;   // characters taken
    int                bad_acc;  // accesses outside the two bytes
    int                wcnt;     // cycles the request has waited
    logic [CHAR_W-1:0] tx_q[$];  // characters waiting to be posted

    // defined levels before the first edge
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 8'h5A;
    end

    // memory side first; the program only runs while emulation is not halted
    always @(posedge clk) begin
        if (!rst_b) begin
            ob      <= 8'h00;
            ib      <= 8'h00;
            mem_ack <= 1'b0;
            wcnt    <= 0;
            rx_cnt  <= 0;
            bad_acc <= 0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;  // released bus shows no stale byte
            wcnt      <= 0;
        end else if (mem_req && wcnt < ack_dly) begin
            wcnt <= wcnt + 1;  // slow answer
        end else if (mem_req) begin
            mem_ack <= 1'b1;
            if (!mem_we && mem_addr == base) begin
                mem_rdata <= ob;
            end else if (mem_we && mem_addr == base && mem_wdata == 8'h00) begin
                ob <= 8'h00;
            end else if (mem_we && mem_addr == base + 20'h00001) begin
                ib    <= mem_wdata;
                in_wr <= mem_wdata;
            end else begin
                bad_acc <= bad_acc + 1;
            end
        end else if (run_mode && !halt_emul) begin
            if (ib[7]) begin
                rx_char <= ib[6:0];
                rx_cnt  <= rx_cnt + 1;
                ib      <= {1'b0, ib[6:0]};
                if (echo_en && !ob[7]) begin
                    ob <= ib;
                end
            end else if (tx_q.size() != 0 && !ob[7]) begin
                ob <= {1'b1, tx_q.pop_front()};
            end
        end
    end
endmodule

/* File: tb_top.sv */
// self-checking bench for the target character mailbox
// assumes the mailbox package and the target program model are compiled first
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb_top
    import mailbox_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 3000;  // shortened poll, still longer than the resample gap
    // stimulus, all defined at time zero
    logic              clk           = 1'b0;
    logic              rst_b         = 1'b0;
    logic              bridge_start  = 1'b0;
    logic [ADDR_W-1:0] bridge_addr   = 20'h012FF;  // base+1 carries into the next byte
    logic              run_mode      = 1'b1;
    logic              break_pending = 1'b0;
    logic              host_valid    = 1'b0;
    logic [CHAR_W-1:0] host_data     = 7'h00;
    logic              out_ready     = 1'b1;
    logic              echo_en       = 1'b0;
    logic [3:0]        ack_dly       = 4'h0;
    // design outputs
    logic mailbox_active, report_break, host_ready, out_valid, mem_req, mem_we, mem_ack;
    logic halt_emul, halt_d, req_d;
    logic [CHAR_W-1:0] out_data;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]        mem_wdata, mem_rdata;
    // bookkeeping
    int   error_cnt = 0, checked = 0, hl = 0, since = 0, idle = 0, kind = 0;
    int   breaks = 0, reqs = 0, rq0, i;
    logic gap_en = 1'b1;  // off while the port stalls, the gap then stretches

    target_char_mailbox #(.POLL_CYCLES(P)) dut (.clk(clk), .rst_b(rst_b),
        .bridge_start(bridge_start), .bridge_addr(bridge_addr), .run_mode(run_mode),
        .break_pending(break_pending), .mailbox_active(mailbox_active),
        .report_break(report_break), .host_valid(host_valid), .host_data(host_data),
        .host_ready(host_ready), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .halt_emul(halt_emul));
    target_prog_model u_tgt (.clk(clk), .rst_b(rst_b), .run_mode(run_mode),
        .halt_emul(halt_emul), .base(bridge_addr), .echo_en(echo_en), .ack_dly(ack_dly),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    // window watcher on settled values: halt length, poll spacing, resample gap
    always @(negedge clk) begin
        since++;
        if (report_break === 1'b1) breaks++;
        if (mem_req && !req_d) reqs++;
        if (halt_emul) begin
            hl++;
        end else if (hl != 0) begin
            `CHK(hl >= HALT_CYC, 1'b1)
            hl = 0;
        end
        // poll spacing holds after an empty read and after an inbound write alike
        if (halt_emul && !halt_d && !mem_we) begin
            if (gap_en && kind != 2) `CHK(since >= P, 1'b1)
            if (gap_en && kind == 2) `CHK(idle <= GAP_CYC + 16, 1'b1)
            since = 0;
        end
        // counted after the look, so the rising halt still sees the whole gap
        idle = halt_emul ? 0 : idle + 1;
        if (halt_emul && !halt_d) kind = mem_we ? 3 : 1;
        if (mem_req && mem_we && mem_addr == bridge_addr) kind = 2;
        halt_d = halt_emul;
        req_d  = mem_req;
    end

    // prints the verdict and ends the run
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a wait that ran out counts as a mismatch
    task automatic wait_out(input int n);
        if (n >= 20000) begin
            error_cnt++;
            give_verdict();
        end
    endtask

    // offer one host character, held until the edge that takes it
    task automatic send_host(input logic [CHAR_W-1:0] c);
        @(posedge clk);
        host_data  <= c;
        host_valid <= 1'b1;
        for (i = 0; i < 20000; i++) begin
            @(negedge clk);
            if (host_ready === 1'b1) break;
        end
        wait_out(i);
        @(posedge clk);
        host_valid <= 1'b0;
    endtask

    // wait for one character at the controlling port and compare it
    task automatic expect_out(input logic [CHAR_W-1:0] c);
        for (i = 0; i < 20000; i++) begin
            @(negedge clk);
            if (out_valid === 1'b1 && out_ready === 1'b1) break;
        end
        wait_out(i);
        `CHK(out_data, c)
        @(posedge clk);
    endtask

    // enter the mode and check the quiet state before it
    task automatic s_enter();
        @(negedge clk);
        `CHK({mailbox_active, out_valid, mem_req, host_ready}, 4'h0)
        @(posedge clk);
        bridge_start <= 1'b1;
        @(posedge clk);
        bridge_start <= 1'b0;
        @(negedge clk);
        `CHK({mailbox_active, host_ready}, 2'h3)
    endtask

    // two target characters back to back: the second rides the resample
    task automatic s_collect();
        u_tgt.tx_q.push_back(7'h48);
        u_tgt.tx_q.push_back(7'h69);
        expect_out(7'h48);
        expect_out(7'h69);
        `CHK(u_tgt.ob, 8'h00)
    endtask

    // host characters with echo and a slow memory answer
    task automatic s_host();
        echo_en <= 1'b1;
        ack_dly <= 4'h3;
        send_host(7'h41);
        expect_out(7'h41);
        `CHK(u_tgt.in_wr, 8'hC1)
        `CHK(u_tgt.rx_char, 7'h41)
        `CHK(u_tgt.ib, 8'h41)
        send_host(7'h42);
        expect_out(7'h42);
        `CHK(u_tgt.rx_cnt, 2)
        echo_en <= 1'b0;
    endtask

    // port stalls: two buffered, a third held, the fourth waits uncollected
    task automatic s_stall();
        gap_en    <= 1'b0;
        out_ready <= 1'b0;
        u_tgt.tx_q.push_back(7'h31);
        u_tgt.tx_q.push_back(7'h32);
        u_tgt.tx_q.push_back(7'h33);
        u_tgt.tx_q.push_back(7'h34);
        for (i = 0; i < 20000; i++) begin
            @(negedge clk);
            if (u_tgt.tx_q.size() == 0 && u_tgt.ob === 8'hB4) break;
        end
        wait_out(i);
        repeat (P + HALT_CYC) @(negedge clk);
        `CHK(u_tgt.ob, 8'hB4)
        @(posedge clk);
        out_ready <= 1'b1;
        expect_out(7'h31);
        expect_out(7'h32);
        expect_out(7'h33);
        expect_out(7'h34);
        gap_en <= 1'b1;
    endtask

    // target stopped with a break pending: no access, then escape pair exits
    task automatic s_stop();
        @(posedge clk);
        run_mode      <= 1'b0;
        break_pending <= 1'b1;
        repeat (HALT_CYC + GAP_CYC + 4) @(negedge clk);
        rq0 = reqs;
        repeat (2 * P) @(negedge clk);
        send_host(7'h58);
        repeat (50) @(negedge clk);
        `CHK(reqs, rq0)
        send_host(ESC_CHAR);
        send_host(ESC_CHAR);
        repeat (6) @(negedge clk);
        `CHK({mailbox_active, host_ready}, 2'h0)
        `CHK(breaks, 1)
        `CHK(u_tgt.bad_acc, 0)
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        s_enter();
        s_collect();
        s_host();
        s_stall();
        s_stop();
        give_verdict();
    end
endmodule
